// [rtl/can_msg_buffer_rx_fifo.v]
// Purpose: CAN message buffers, background-to-foreground receive FIFO
// Assumes: protocol engine drives frame byte strobes and frame end status
// Notes: Wishbone classic slave, one wait state, 8-bit data in low lanes
//
// The Wishbone slave port was chosen for this implementation.
`include "can_msg_buffer_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module can_msg_buffer_rx_fifo #(
    parameter DEPTH = `RX_FIFO_DEPTH,
    parameter PW = 3,
    parameter NTX = `TX_BUFFERS
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:2] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // receive side of protocol engine
    input wire frm_byte_valid_i,
    input wire [1:0] frm_byte_idx_i,
    input wire [7:0] frm_byte_i,
    input wire frm_done_i,
    input wire frm_ok_i,
    input wire [7:0] filter_match_i,
    // transmit side of protocol engine
    input wire tx_start_i,
    input wire arb_lost_i,
    input wire [NTX-1:0] tx_done_i,
    input wire [1:0] tx_idx_i,
    output reg [31:0] tx_ident_o,
    output reg tx_ide_o,
    output reg tx_rtr_o,
    output reg rx_ack_en_o,
    // interrupt requests
    output reg rx_irq_o,
    output reg ovr_irq_o
);

    localparam [PW:0] DEPTH_C = DEPTH;
    localparam [PW-1:0] LAST_C = DEPTH - 1;

    reg [31:0] bg_q;
    reg [34:0] fifo_mem [0:DEPTH-1];
    reg [31:0] tx_mem [0:NTX-1];
    reg [PW-1:0] wr_ptr_q;
    reg [PW-1:0] rd_ptr_q;
    reg [PW:0] count_q;
    reg ovr_q;
    reg [2:0] ctrl_q;
    reg [NTX-1:0] tx_empty_q;
    reg [NTX-1:0] tx_sel_q;
    reg own_q;
    reg [2:0] hit_d;
    reg [1:0] sel_idx_d;
    reg sel_any_d;
    reg [31:0] rd_d;
    reg [31:0] tx_word_d;
    integer i;
    integer k;

    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire bus_wr = bus_req & we_i & sel_i[0];
    wire rx_full = (count_q != {(PW+1){1'b0}});
    wire loopback = ctrl_q[`LOOPBACK_BIT];
    wire own_blocked = own_q & ~loopback;
    wire fifo_full = (count_q == DEPTH_C);
    wire frame_good = frm_done_i & frm_ok_i & (filter_match_i != 8'h00);
    wire push_try = frame_good & ~own_blocked;
    wire push = push_try & ~fifo_full;
    wire pop = bus_wr & (adr_i == `IDX_RX_FLAG_REG) & dat_i[`RXF_BIT] & rx_full;
    wire [34:0] fg_w = fifo_mem[rd_ptr_q];
    wire tx_ok = sel_any_d & tx_empty_q[sel_idx_d];

    // lowest matching filter wins, lowest selected tx buffer wins
    always @* begin
        hit_d = 3'h0;
        for (i = 7; i >= 0; i = i - 1) begin
            if (filter_match_i[i]) begin
                hit_d = i[2:0];
            end
        end
        sel_idx_d = 2'h0;
        sel_any_d = 1'b0;
        for (i = NTX - 1; i >= 0; i = i - 1) begin
            if (tx_sel_q[i]) begin
                sel_idx_d = i[1:0];
                sel_any_d = 1'b1;
            end
        end
        tx_word_d = tx_mem[sel_idx_d];
    end

    // read data mux
    always @* begin
        rd_d = 32'h0;
        case (adr_i)
            `IDX_IDENT_BYTE_0: begin
                if (rx_full) begin
                    rd_d[7:0] = fg_w[31:24];
                end
            end
            `IDX_IDENT_BYTE_1: begin
                if (rx_full) begin
                    rd_d[7:0] = fg_w[23:16];
                end
            end
            `IDX_IDENT_BYTE_2: begin
                if (rx_full) begin
                    rd_d[7:0] = fg_w[15:8];
                end
            end
            `IDX_IDENT_BYTE_3: begin
                if (rx_full) begin
                    rd_d[7:0] = fg_w[7:0];
                end
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
                if (tx_ok) begin
                    rd_d[7:0] = tx_word_d[8*(3-adr_i[3:2]) +: 8];
                end
            end
            `IDX_RX_FLAG_REG: begin
                rd_d[`RXF_BIT] = rx_full;
                rd_d[`OVR_BIT] = ovr_q;
                rd_d[`HIT_MSB:`HIT_LSB] = rx_full ? fg_w[34:32] : 3'h0;
            end
            `IDX_CONTROL_REG_ONE: begin
                rd_d[2:0] = ctrl_q;
            end
            `IDX_TX_FLAG_REG: begin
                rd_d[NTX-1:0] = tx_empty_q;
            end
            `IDX_TX_BUFFER_SELECT_REG: begin
                rd_d[NTX-1:0] = tx_sel_q;
            end
            default: begin
                rd_d = 32'h0;
            end
        endcase
    end

    // bus answer, one cycle after the request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_d : 32'h0;
        end
    end

    // background buffer and storage arrays, never reset
    always @(posedge clk_i) begin
        if (frm_byte_valid_i) begin
            bg_q[8*(3-frm_byte_idx_i) +: 8] <= frm_byte_i;
        end
        if (push) begin
            fifo_mem[wr_ptr_q] <= {hit_d, bg_q};
        end
        if (bus_wr && adr_i[5:4] == 2'b01 && tx_ok) begin
            tx_mem[sel_idx_d][8*(3-adr_i[3:2]) +: 8] <= dat_i[7:0];
        end
        // rx byte indices 0..3 have no write path
    end

    // fifo pointers, flags and control
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= {PW{1'b0}};
            rd_ptr_q <= {PW{1'b0}};
            count_q <= {(PW+1){1'b0}};
            ovr_q <= 1'b0;
            ctrl_q <= `CONTROL_RESET;
            tx_empty_q <= {NTX{1'b1}};
            tx_sel_q <= {NTX{1'b0}};
            own_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_C) ? {PW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_C) ? {PW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
            if (push_try & fifo_full) begin
                ovr_q <= 1'b1;
            end else if (bus_wr && adr_i == `IDX_RX_FLAG_REG && dat_i[`OVR_BIT]) begin
                ovr_q <= 1'b0;
            end
            if (bus_wr && adr_i == `IDX_CONTROL_REG_ONE) begin
                ctrl_q <= dat_i[2:0];
            end
            if (bus_wr && adr_i == `IDX_TX_BUFFER_SELECT_REG) begin
                tx_sel_q <= dat_i[NTX-1:0];
            end
            // software writes one to hand a buffer over, completion sets it back
            for (k = 0; k < NTX; k = k + 1) begin
                if (tx_done_i[k]) begin
                    tx_empty_q[k] <= 1'b1;
                end else if (bus_wr && adr_i == `IDX_TX_FLAG_REG && dat_i[k]) begin
                    tx_empty_q[k] <= 1'b0;
                end
            end
            if (arb_lost_i | frm_done_i) begin
                own_q <= 1'b0;
            end else if (tx_start_i) begin
                own_q <= 1'b1;
            end
        end
    end

    // engine-facing and interrupt outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_ident_o <= 32'h0;
            tx_ide_o <= 1'b0;
            tx_rtr_o <= 1'b0;
            rx_ack_en_o <= 1'b1;
            rx_irq_o <= 1'b0;
            ovr_irq_o <= 1'b0;
        end else begin
            tx_ident_o <= tx_mem[tx_idx_i];
            tx_ide_o <= tx_mem[tx_idx_i][16+`IDE_BIT];
            tx_rtr_o <= tx_mem[tx_idx_i][16+`IDE_BIT] ?
                tx_mem[tx_idx_i][`EXT_RTR_BIT] : tx_mem[tx_idx_i][16+`STD_RTR_BIT];
            rx_ack_en_o <= ~((own_q | tx_start_i) & ~loopback & ~arb_lost_i);
            rx_irq_o <= rx_full & ctrl_q[`RX_IE_BIT];
            ovr_irq_o <= ovr_q & ctrl_q[`OVR_IE_BIT];
        end
    end

endmodule

`default_nettype wire

// [inc/can_msg_buffer_consts.vh]
// Purpose: constants for the CAN message buffer and receive FIFO block
// Assumes: word-aligned Wishbone registers, byte address = 4 * index
// Notes: identifier byte indices 0..3 are the printed offsets
`ifndef CAN_MSG_BUFFER_CONSTS_VH
`define CAN_MSG_BUFFER_CONSTS_VH

// register indices
`define IDX_IDENT_BYTE_0 4'h0
`define IDX_IDENT_BYTE_1 4'h1
`define IDX_IDENT_BYTE_2 4'h2
`define IDX_IDENT_BYTE_3 4'h3
`define IDX_TX_IDENT_BASE 4'h4
`define IDX_RX_FLAG_REG 4'h8
`define IDX_CONTROL_REG_ONE 4'h9
`define IDX_TX_FLAG_REG 4'ha
`define IDX_TX_BUFFER_SELECT_REG 4'hb

// rx_flag_reg fields
`define RXF_BIT 0
`define OVR_BIT 1
`define HIT_LSB 4
`define HIT_MSB 6

// control_reg_one fields
`define LOOPBACK_BIT 0
`define RX_IE_BIT 1
`define OVR_IE_BIT 2
`define CONTROL_RESET 3'h0

// identifier byte 1 fields, except EXT_RTR_BIT which is in byte 3
`define IDE_BIT 3
`define STD_RTR_BIT 4
`define EXT_RTR_BIT 0

// defaults
`define RX_FIFO_DEPTH 5
`define TX_BUFFERS 3

`endif

// [verif/can_rx_chk_assertions.sv]
// Purpose: port checker
// Assumes: one clock domain
// Notes: bound into the top
`timescale 1ns/1ps
`default_nettype none
module can_rx_chk (
    // clock, reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // engine
    input wire logic frm_done_i,
    input wire logic frm_ok_i,
    input wire logic [7:0] filter_match_i,
    input wire logic tx_start_i,
    input wire logic arb_lost_i,
    input wire logic rx_ack_en_o,
    input wire logic rx_irq_o,
    input wire logic ovr_irq_o
);
    wire req_w = cyc_i && stb_i;
    wire good_w = frm_done_i && frm_ok_i && filter_match_i != 8'h00;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence bad_s;
        frm_done_i && !good_w && !req_w ##1 !req_w;
    endsequence
    ack_next_a: assert property (req_w && !ack_o |=> ack_o) else $error("no ack");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("long ack");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat busy");
    byte_lane_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits");
    bad_frame_a: assert property (bad_s |=> !$rose(rx_irq_o))
        else $error("bad frame irq");
    rx_irq_a: assert property ($rose(rx_irq_o) |-> $past(good_w, 2) || $past(req_w, 2))
        else $error("stray rx irq");
    ovr_irq_a: assert property ($rose(ovr_irq_o) |-> $past(good_w, 2) || $past(req_w, 2))
        else $error("stray ovr irq");
    arb_back_a: assert property (arb_lost_i && !tx_start_i ##1 !tx_start_i |=> rx_ack_en_o)
        else $error("ack enable low");
endmodule
bind can_msg_buffer_rx_fifo can_rx_chk can_rx_chk_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .dat_o, .ack_o, .frm_done_i, .frm_ok_i, .filter_match_i, .tx_start_i, .arb_lost_i,
    .rx_ack_en_o, .rx_irq_o, .ovr_irq_o);
`default_nettype wire

// [verif/can_frame_src.sv]
// Purpose: frame source in place of other nodes
// Assumes: caller enters just after a rising edge
// Notes: idle byte, ok and match lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module can_frame_src (
    // clock
    input wire logic clk_i,
    // frame link
    output var logic bv_o,
    output var logic [1:0] bidx_o,
    output var logic [7:0] byte_o,
    output var logic done_o,
    output var logic ok_o,
    output var logic [7:0] match_o
);
    initial {bv_o, bidx_o, byte_o, done_o, ok_o, match_o} = 21'h0;
    task automatic send(input logic [31:0] id, input logic ok, input logic [7:0] hit);
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            bv_o <= 1'b1;
            bidx_o <= i[1:0];
            byte_o <= id[31-8*i -: 8];
            @(posedge clk_i);
        end
        bv_o <= 1'b0;
        byte_o <= ~id[7:0];
        done_o <= 1'b1;
        ok_o <= ok;
        match_o <= hit;
        @(posedge clk_i);
        done_o <= 1'b0;
        ok_o <= ~ok;
        match_o <= ~hit;
    endtask
endmodule
`default_nettype wire

// [verif/can_msg_buffer_rx_fifo_tb.sv]
// Purpose: self-checking bench
// Assumes: DEPTH 5, engine reads tx buffer 0
// Notes: registers over classic Wishbone
`timescale 1ns/1ps
`default_nettype none
module can_msg_buffer_rx_fifo_tb;
    localparam logic [31:0] TXID = 32'h123d5679;
    localparam logic [31:0] RXID = 32'h9abcdef1;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0, stb = 0, we = 0, ts = 0, al = 0;
    logic [3:0] adr = 0;
    logic [31:0] wdat = 0, rd = 0;
    logic [2:0] tdn = 0;
    wire [31:0] dat, tid;
    wire [7:0] byt, match;
    wire [1:0] bidx;
    wire ack, bv, done, ok, ide, rtr, aen, rirq, oirq;
    integer n_errors = 0, checked = 0, i;
    initial forever #2 clk_i = ~clk_i;
    can_msg_buffer_rx_fifo can_msg_buffer_rx_fifo_inst (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
        .dat_o(dat), .ack_o(ack), .frm_byte_valid_i(bv), .frm_byte_idx_i(bidx),
        .frm_byte_i(byt), .frm_done_i(done), .frm_ok_i(ok), .filter_match_i(match),
        .tx_start_i(ts), .arb_lost_i(al), .tx_done_i(tdn), .tx_idx_i(2'h0), .tx_ident_o(tid),
        .tx_ide_o(ide), .tx_rtr_o(rtr), .rx_ack_en_o(aen), .rx_irq_o(rirq), .ovr_irq_o(oirq));
    can_frame_src can_frame_src_inst (.clk_i(clk_i), .bv_o(bv), .bidx_o(bidx), .byte_o(byt),
        .done_o(done), .ok_o(ok), .match_o(match));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked = checked + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        integer t;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        // look at ack mid-cycle, where it is settled; it stands until the next rising edge
        @(negedge clk_i);
        for (t = 0; t < 50 && ack !== 1'b1; t = t + 1) @(negedge clk_i);
        rd = dat;
        @(posedge clk_i);
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        wb(0, a, 0);
        chk(rd, e);
    endtask
    task automatic kick(input logic arb);
        if (arb) al <= 1; else ts <= 1;
        @(posedge clk_i);
        {al, ts} <= 2'b00;
        repeat (2) @(posedge clk_i);
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        rd_chk(4'h0, 32'h0);
        wb(1, 4'hb, 32'h1);
        for (i = 0; i < 4; i = i + 1) wb(1, 4'h4 + i[3:0], {24'h0, TXID[31-8*i -: 8]});
        for (i = 0; i < 4; i = i + 1) rd_chk(4'h4 + i[3:0], {24'h0, TXID[31-8*i -: 8]});
        chk(tid, TXID);
        chk({30'h0, ide, rtr}, 32'h3);
        wb(1, 4'ha, 32'h1);
        rd_chk(4'h4, 32'h0);
        tdn <= 3'h1;
        @(posedge clk_i);
        tdn <= 3'h0;
        rd_chk(4'h4, 32'h12);
        wb(1, 4'h5, 32'h30);
        chk({30'h0, ide, rtr}, 32'h1);
        wb(1, 4'h9, 32'h2);
        can_frame_src_inst.send(RXID, 1, 8'h60);
        wb(1, 4'h0, 32'h0);
        for (i = 0; i < 4; i = i + 1) rd_chk(i[3:0], {24'h0, RXID[31-8*i -: 8]});
        rd_chk(4'h8, 32'h51);
        chk(32'(rirq), 1);
        wb(1, 4'h8, 32'h1);
        chk(32'(rirq), 0);
        can_frame_src_inst.send(32'h11111111, 0, 8'h01);
        can_frame_src_inst.send(32'h22222222, 1, 8'h00);
        can_frame_src_inst.send(32'h33333333, 1, 8'h80);
        rd_chk(4'h8, 32'h71);
        rd_chk(4'h3, 32'h33);
        wb(1, 4'h8, 32'h1);
        wb(1, 4'h9, 32'h6);
        for (i = 0; i < 7; i = i + 1) begin
            if (i == 6) wb(1, 4'h8, 32'h1);
            can_frame_src_inst.send({24'h0, i[7:0]}, 1, 8'h01);
        end
        chk(32'(oirq), 1);
        for (i = 0; i < 5; i = i + 1) begin
            rd_chk(4'h3, i < 4 ? i + 1 : 6);
            wb(1, 4'h8, 32'h1);
        end
        rd_chk(4'h3, 32'h0);
        wb(1, 4'h8, 32'h2);
        chk(32'(oirq), 0);
        kick(0);
        chk(32'(aen), 0);
        kick(1);
        chk(32'(aen), 1);
        kick(0);
        can_frame_src_inst.send(32'h44444444, 1, 8'h01);
        wb(0, 4'h8, 0);
        chk(rd & 32'h1, 0);
        wb(1, 4'h9, 32'h3);
        kick(0);
        chk(32'(aen), 1);
        can_frame_src_inst.send(32'h55555555, 1, 8'h02);
        rd_chk(4'h8, 32'h11);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors = n_errors + 1;
        test_done;
    end
endmodule
`default_nettype wire
